// ---- src/rra_top.sv ----
`timescale 1ns/100ps
// ring redundancy assist: axi4-lite registers, beacon timing, supervisor watch, hsr filters
module rra_top
   import rra_pkg::*;
#(
   parameter int AGE_TICK = AGE_TICK_DEF // cycles per aging step
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [AW-1:0]    s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [AW-1:0]    s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   input  wire logic             frm_vld,   // received frame header
   input  wire rra_frm_s         frm,
   output logic                  vrd_vld,   // verdict, one cycle later
   output rra_vrd_s              vrd,
   input  wire logic [NP-1:0]    acl_to,    // acl count-mode timeout pulses
   output logic [NP-1:0]         bcn_tx,    // beacon launch per port, one pulse
   output logic [NFLD-1:0][31:0] bcn_fld,   // beacon frame field words
   output logic [NP-1:0]         fwd_en,    // port may forward ordinary traffic
   output logic                  flush_req, // held until acknowledged
   input  wire logic             flush_ack,
   output logic                  sup_lost   // active supervisor lost
);

   // byte-lane merge for the register-file words; status and flush writes bypass it
   function automatic logic [31:0] wb(input logic [31:0] o, input logic [31:0] n,
                                      input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
      end
      return r;
   endfunction

   function automatic logic is_fld(input logic [AW-1:0] a);
      return a >= A_FLD0 && a < A_FLDE;
   endfunction

   function automatic logic [2:0] fi(input logic [AW-1:0] a);
      return 3'((a - A_FLD0) >> 2);
   endfunction

   function automatic logic mapd(input logic [AW-1:0] a);
      return is_fld(a) || a == A_DUPC || (a >= A_RMAP && a <= A_TDAT);
   endfunction

   // folds both addresses into set index (low) and tag (high)
   function automatic logic [15:0] hsh(input logic [47:0] s, input logic [47:0] d);
      logic [95:0] k;
      logic [15:0] h;
      k = {s, d};
      h = '0;
      for (int i = 0; i < 6; i++) begin
         h = h ^ k[i*16 +: 16];
      end
      return h;
   endfunction

   logic [AW-1:0]          awa_ff;
   logic [31:0]            wd_ff;
   logic [3:0]             ws_ff;
   logic                   awf_ff, wf_ff, awr_ff, wr_ff, bv_ff, arr_ff, rv_ff;
   logic [1:0]             br_ff, rr_ff;
   logic [31:0]            rd_ff, rmux;
   logic [AW-1:0]          ra;
   logic                   wr_go, ivl_wr;
   logic [NFLD-1:0][31:0]  fld_ff;
   logic [31:0]            rmap_ff, hmap_ff, lkc1_ff, pc2_ff, stp_ff;
   logic [31:0]            macl_ff, mach_ff, dupc_ff, tidx_ff, tdat;
   logic [NP-1:0]          to_ff, rto, bcn_ff, fwd_ff;
   logic                   lost_ff, flush_ff, vv_ff, fire;
   rra_vrd_s               vrd_ff;
   rra_win_e               wst_ff;
   logic [NP-1:0]          first_ff;
   logic [31:0]            wcnt_ff, wus_ff, bt_ff, us_ff, agc_ff;
   logic [SET_W-1:0]       sp_ff, set;
   rra_ent_s               tbl_ff [NSET][2];
   logic [NSET-1:0][1:0]   vld_ff, old_ff;
   logic [15:0]            hk;
   logic [1:0]             hit, dupw;
   logic                   ring_f, self_f, dup_f, upd, vw, wsel, age_tick;
   logic [47:0]            mac;

   assign s_axi_awready = awr_ff;
   assign s_axi_wready  = wr_ff;
   assign s_axi_bvalid  = bv_ff;
   assign s_axi_bresp   = br_ff;
   assign s_axi_arready = arr_ff;
   assign s_axi_rvalid  = rv_ff;
   assign s_axi_rdata   = rd_ff;
   assign s_axi_rresp   = rr_ff;
   assign vrd_vld       = vv_ff;
   assign vrd           = vrd_ff;
   assign bcn_tx        = bcn_ff;
   assign bcn_fld       = fld_ff;
   assign fwd_en        = fwd_ff;
   assign flush_req     = flush_ff;
   assign sup_lost      = lost_ff;

   // write channel: address and data taken in either order, answered once both are in
   assign wr_go  = awf_ff && wf_ff && !bv_ff;
   assign ivl_wr = wr_go && awa_ff == A_IVL;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awr_ff <= 1'b1;
         wr_ff  <= 1'b1;
         awf_ff <= 1'b0;
         wf_ff  <= 1'b0;
         bv_ff  <= 1'b0;
         br_ff  <= RESP_OK;
         awa_ff <= '0;
         wd_ff  <= '0;
         ws_ff  <= '0;
      end else begin
         if (s_axi_awvalid && awr_ff) begin
            awa_ff <= {s_axi_awaddr[AW-1:2], 2'h0};
            awf_ff <= 1'b1;
            awr_ff <= 1'b0;
         end
         if (s_axi_wvalid && wr_ff) begin
            wd_ff <= s_axi_wdata;
            ws_ff <= s_axi_wstrb;
            wf_ff <= 1'b1;
            wr_ff <= 1'b0;
         end
         if (wr_go) begin
            awf_ff <= 1'b0;
            wf_ff  <= 1'b0;
            bv_ff  <= 1'b1;
            br_ff  <= mapd(awa_ff) ? RESP_OK : RESP_ERR; // unmapped writes are dropped
         end
         if (bv_ff && s_axi_bready) begin
            bv_ff  <= 1'b0;
            awr_ff <= 1'b1;
            wr_ff  <= 1'b1;
         end
      end
   end

   // read mux; the table word is looked up through the index register
   always_comb begin
      ra   = {s_axi_araddr[AW-1:2], 2'h0};
      tdat = 32'({vld_ff[tidx_ff[8:1]][tidx_ff[0]], old_ff[tidx_ff[8:1]][tidx_ff[0]],
                  tbl_ff[tidx_ff[8:1]][tidx_ff[0]]});
      rmux = '0;
      if (is_fld(ra)) rmux = fld_ff[fi(ra)];
      case (ra)
         A_DUPC: rmux = dupc_ff;
         A_RMAP: rmux = rmap_ff;
         A_HMAP: rmux = hmap_ff;
         A_LKC1: rmux = lkc1_ff;
         A_LKC2: rmux = 32'(flush_ff);
         A_PC2:  rmux = pc2_ff;
         A_STP:  rmux = stp_ff;
         A_MACL: rmux = macl_ff;
         A_MACH: rmux = mach_ff;
         A_STAT: rmux = 32'({wst_ff == W_OPEN, lost_ff, 1'b0, to_ff});
         A_TIDX: rmux = tidx_ff;
         A_TDAT: rmux = tdat;
         default: ;
      endcase
   end

   // read channel: one read under way, data one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arr_ff <= 1'b1;
         rv_ff  <= 1'b0;
         rd_ff  <= '0;
         rr_ff  <= RESP_OK;
      end else if (s_axi_arvalid && arr_ff) begin
         arr_ff <= 1'b0;
         rv_ff  <= 1'b1;
         rd_ff  <= rmux;
         rr_ff  <= mapd(ra) ? RESP_OK : RESP_ERR;
      end else if (rv_ff && s_axi_rready) begin
         rv_ff  <= 1'b0;
         arr_ff <= 1'b1;
      end
   end

   // register file; status and flush bits live with their own logic
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fld_ff        <= '0;
         fld_ff[I_IVL] <= IVL_RST;
         rmap_ff       <= '0;
         hmap_ff       <= '0;
         lkc1_ff       <= '0;
         pc2_ff        <= '0;
         stp_ff        <= STP_MSK; // all ports forwarding after reset
         macl_ff       <= '0;
         mach_ff       <= '0;
         dupc_ff       <= '0;
         tidx_ff       <= '0;
      end else if (wr_go) begin
         if (is_fld(awa_ff)) begin
            fld_ff[fi(awa_ff)] <= wb(fld_ff[fi(awa_ff)], wd_ff, ws_ff) &
                                  (fi(awa_ff) == I_CTL ? CTL_MSK : '1);
         end
         case (awa_ff)
            A_DUPC: dupc_ff <= wb(dupc_ff, wd_ff, ws_ff) & CTL_MSK;
            A_RMAP: rmap_ff <= wb(rmap_ff, wd_ff, ws_ff) & MAP_MSK;
            A_HMAP: hmap_ff <= wb(hmap_ff, wd_ff, ws_ff) & MAP_MSK;
            A_LKC1: lkc1_ff <= wb(lkc1_ff, wd_ff, ws_ff) & CTL_MSK;
            A_PC2:  pc2_ff  <= wb(pc2_ff, wd_ff, ws_ff) & MAP_MSK;
            A_STP:  stp_ff  <= wb(stp_ff, wd_ff, ws_ff) & STP_MSK;
            A_MACL: macl_ff <= wb(macl_ff, wd_ff, ws_ff);
            A_MACH: mach_ff <= wb(mach_ff, wd_ff, ws_ff) & MACH_MSK;
            A_TIDX: tidx_ff <= wb(tidx_ff, wd_ff, ws_ff) & TIDX_MSK;
            default: ;
         endcase
      end
   end

   // beacon interval: microsecond prescaler and interval count
   assign fire = fld_ff[I_CTL][B_GEN] && us_ff == 32'(US_CYC - 1) &&
                 {1'b0, bt_ff} + 33'h1 >= {1'b0, fld_ff[I_IVL]};
   always_ff @(posedge aclk) begin
      if (!aresetn || !fld_ff[I_CTL][B_GEN] || ivl_wr) begin
         us_ff <= '0;
         bt_ff <= '0;
      end else if (us_ff == 32'(US_CYC - 1)) begin
         us_ff <= '0;
         bt_ff <= fire ? '0 : bt_ff + 32'h1;
      end else begin
         us_ff <= us_ff + 32'h1;
      end
   end

   // both ring ports launch together so the copies leave as a pair
   always_ff @(posedge aclk) begin
      if (!aresetn) bcn_ff <= '0;
      else bcn_ff <= fire ? rmap_ff[NP-1:0] : '0;
   end

   // port blocking follows the state bits; flush request held until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fwd_ff   <= '0;
         flush_ff <= 1'b0;
      end else begin
         for (int p = 0; p < NP; p++) begin
            fwd_ff[p] <= stp_ff[p*STP_W + STP_FWD] || stp_ff[p*STP_W + STP_LRN];
         end
         if (wr_go && awa_ff == A_LKC2 && ws_ff[0] && wd_ff[B_FLUSH]) flush_ff <= 1'b1;
         else if (flush_ack) flush_ff <= 1'b0;
      end
   end

   // ring-port timeouts are sticky, write one to clear; a new timeout beats the clear
   assign rto = acl_to & rmap_ff[NP-1:0];
   always_ff @(posedge aclk) begin
      if (!aresetn) to_ff <= '0;
      else if (wr_go && awa_ff == A_STAT) to_ff <= (to_ff & ~wd_ff[NP-1:0]) | rto;
      else to_ff <= to_ff | rto;
   end

   // backup supervisor: second port must time out inside the window
   // the window keeps its own microsecond count, the beacon one is held at zero while the generator is off
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wst_ff   <= W_IDLE;
         first_ff <= '0;
         wcnt_ff  <= '0;
         wus_ff   <= '0;
         lost_ff  <= 1'b0;
      end else begin
         if (wr_go && awa_ff == A_STAT && ws_ff[1] && wd_ff[ST_LOST]) lost_ff <= 1'b0;
         unique case (wst_ff)
            W_IDLE: begin
               if (fld_ff[I_CTL][B_BKP] && rto != '0) begin
                  if (rto == rmap_ff[NP-1:0]) lost_ff <= 1'b1;
                  else begin
                     first_ff <= rto;
                     wcnt_ff  <= '0;
                     wus_ff   <= '0;
                     wst_ff   <= W_OPEN;
                  end
               end
            end
            W_OPEN: begin
               wus_ff <= (wus_ff == 32'(US_CYC - 1)) ? '0 : wus_ff + 32'h1;
               if (!fld_ff[I_CTL][B_BKP] || wcnt_ff > fld_ff[I_WIN]) begin
                  wst_ff <= W_IDLE;
               end else if ((rto & ~first_ff) != '0) begin
                  lost_ff <= 1'b1;
                  wst_ff  <= W_IDLE;
               end else if (wus_ff == 32'(US_CYC - 1)) begin
                  wcnt_ff <= wcnt_ff + 32'h1;
               end
            end
         endcase
      end
   end

   // frame screening: self address and duplicate lookup
   assign mac = {mach_ff[15:0], macl_ff};
   always_comb begin
      hk     = hsh(frm.sa, frm.da);
      set    = hk[SET_W-1:0];
      ring_f = hmap_ff[frm.port];
      for (int w = 0; w < 2; w++) begin
         hit[w]  = vld_ff[set][w] && tbl_ff[set][w].tag == hk[15:8];
         dupw[w] = hit[w] && tbl_ff[set][w].seq == frm.seq &&
                   tbl_ff[set][w].pt != frm.port;
      end
      self_f = frm_vld && (lkc1_ff[B_SAF] || pc2_ff[frm.port]) && frm.sa == mac;
      upd    = frm_vld && frm.hsr && ring_f && dupc_ff[B_DUP];
      dup_f  = upd && dupw != '0;
      vw     = vld_ff[set][0] && !(vld_ff[set][1] && !old_ff[set][1]);
      wsel   = hit[0] ? 1'b0 : (hit[1] ? 1'b1 : vw);
   end

   // verdict register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vv_ff  <= 1'b0;
         vrd_ff <= '0;
      end else begin
         vv_ff  <= frm_vld;
         vrd_ff <= '{drop: self_f || dup_f, self_hit: self_f, dup_hit: dup_f};
      end
   end

   // aging: one set per step, two sweeps of its set unseen clear an entry
   assign age_tick = agc_ff == 32'(AGE_TICK - 1);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         agc_ff <= '0;
         sp_ff  <= '0;
      end else if (age_tick) begin
         agc_ff <= '0;
         sp_ff  <= sp_ff + SET_W'(1);
      end else begin
         agc_ff <= agc_ff + 32'h1;
      end
   end

   // flags carry the reset; a frame update wins over the sweep on the same entry
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vld_ff <= '0;
         old_ff <= '0;
      end else begin
         if (age_tick) begin
            for (int w = 0; w < 2; w++) begin
               if (old_ff[sp_ff][w]) vld_ff[sp_ff][w] <= 1'b0;
               old_ff[sp_ff][w] <= 1'b1;
            end
         end
         if (upd) begin
            vld_ff[set][wsel] <= 1'b1;
            old_ff[set][wsel] <= 1'b0;
         end
      end
   end

   // table words need no reset, the valid flags gate them
   always_ff @(posedge aclk) begin
      if (upd) tbl_ff[set][wsel] <= '{tag: hk[15:8], seq: frm.seq, pt: frm.port};
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_wr_both;
      awf_ff && wf_ff && !bv_ff;
   endsequence
   sequence s_pair;
      bcn_ff != '0;
   endsequence

   chk_bus_write: assert property (s_wr_both |=> bv_ff && !awf_ff)
      else $error("write not answered");
   chk_bcn_pair: assert property (s_pair |-> bcn_ff == $past(rmap_ff[NP-1:0]))
      else $error("beacon not sent on ring pair");
   chk_bcn_gate: assert property (!fld_ff[I_CTL][B_GEN] |=> bcn_ff == '0)
      else $error("beacon while generator off");
   chk_bcn_space: assert property (s_pair |=> (bcn_ff == '0)[*8])
      else $error("beacons too close");
   chk_bcn_restart: assert property (ivl_wr |=> (bcn_ff == '0)[*8])
      else $error("beacon right after interval rewrite");
   chk_sup_mode: assert property ($rose(lost_ff) |-> $past(fld_ff[I_CTL][B_BKP]))
      else $error("loss outside backup mode");
   chk_sup_window: assert property ($rose(lost_ff) |->
      $past(wst_ff == W_IDLE) || $past(wcnt_ff <= fld_ff[I_WIN]))
      else $error("loss outside timeout window");
   chk_self_drop: assert property (frm_vld && lkc1_ff[B_SAF] && frm.sa == mac
      |=> vv_ff && vrd_ff.drop && vrd_ff.self_hit)
      else $error("own source not dropped");
   chk_dup_gate: assert property (vrd_ff.dup_hit |-> $past(dupc_ff[B_DUP]))
      else $error("duplicate drop while disabled");
   chk_flush_hold: assert property (flush_ff && !flush_ack |=> flush_ff)
      else $error("flush request dropped early");
   chk_to_sticky: assert property (rto != '0 |=> (to_ff & $past(rto)) == $past(rto))
      else $error("ring timeout not recorded");

endmodule // rra_top

// ---- src/rra_pkg.sv ----
// package: register map, field layout, timing and carrier types of the ring assist
// Summary of operation
// - Two bits in the ring port map pick the DLR ring port pair.
// - Control bit 1 lets hardware send supervisor beacons on its own.
// - Every beacon field comes from the programmable field words.
// - Beacons are spaced by a 32-bit interval, 400 us after reset.
// - Each beacon leaves as a pair, one per ring port, per interval.
// - ACL count-mode timeouts on ring ports raise the timeout indication.
// - Control bit 2 makes a backup; loss needs timeouts on both ring ports.
// - Loss is refused when the two timeouts lie further apart than the window.
// - Clearing a port's two state bits stops its ordinary forwarding.
// - Software orders a flush of dynamic forwarding entries; hardware requests it.
// - Two bits in the HSR port map pick the HSR ring port pair.
// - With self filtering on, a frame whose source equals our MAC is dropped.
// - Self filtering is on globally by bit 6 or per port by the port's own bit in port control 2.
// - Our MAC for filtering comes from the six switch address bytes.
// - Duplicate state lives in a 2-way table of 512 entries, hashed from addresses.
// - Sequence numbers are tracked per address pair with the port last seen; a repeat from the other port drops.
// - Entries age out on their own; overflow may let duplicates through.
// - Duplicate discard only with bit 7 set; software may read the table.
package rra_pkg;
   localparam int          NP      = 7;       // switch ports
   localparam int          AW      = 12;      // register address width
   localparam logic [11:0] A_FLD0  = 12'h608; // first beacon field word
   localparam logic [11:0] A_FLDE  = 12'h628; // one past the last field word
   localparam int          NFLD    = 8;
   localparam logic [11:0] A_CTL   = 12'h610;
   localparam logic [11:0] A_IVL   = 12'h614;
   localparam logic [11:0] A_WIN   = 12'h61C;
   localparam logic [11:0] A_DUPC  = 12'h644;
   localparam logic [11:0] A_RMAP  = 12'h650;
   localparam logic [11:0] A_HMAP  = 12'h654;
   localparam logic [11:0] A_LKC1  = 12'h658;
   localparam logic [11:0] A_LKC2  = 12'h65C;
   localparam logic [11:0] A_PC2   = 12'h660;
   localparam logic [11:0] A_STP   = 12'h664;
   localparam logic [11:0] A_MACL  = 12'h668;
   localparam logic [11:0] A_MACH  = 12'h66C;
   localparam logic [11:0] A_STAT  = 12'h670;
   localparam logic [11:0] A_TIDX  = 12'h674;
   localparam logic [11:0] A_TDAT  = 12'h678;
   localparam logic [2:0]  I_CTL   = 3'((A_CTL - A_FLD0) >> 2);
   localparam logic [2:0]  I_IVL   = 3'((A_IVL - A_FLD0) >> 2);
   localparam logic [2:0]  I_WIN   = 3'((A_WIN - A_FLD0) >> 2);
   localparam int          B_GEN   = 1;       // control: beacon generator on
   localparam int          B_BKP   = 2;       // control: backup supervisor
   localparam int          B_SAF   = 6;       // lookup control 1: self filter all ports
   localparam int          B_DUP   = 7;       // duplicate discard on
   localparam int          B_FLUSH = 0;       // lookup control 2: flush dynamic entries
   localparam int          STP_W   = 4;       // state field stride per port
   localparam int          STP_FWD = 1;
   localparam int          STP_LRN = 2;
   localparam int          ST_LOST = 8;       // status: supervisor lost
   localparam int          ST_WOPN = 9;       // status: timeout window open
   localparam logic [31:0] CTL_MSK = 32'h0000_00FF;
   localparam logic [31:0] MAP_MSK = 32'h0000_007F;
   localparam logic [31:0] STP_MSK = 32'h0FFF_FFFF;
   localparam logic [31:0] MACH_MSK = 32'h0000_FFFF;
   localparam logic [31:0] TIDX_MSK = 32'h0000_01FF;
   localparam int          CYC_NS  = 4;
   localparam int          US_NS   = 1000;
   localparam int          US_CYC  = (US_NS + CYC_NS - 1) / CYC_NS;
   localparam int          BCN_IVL_US = 400;
   localparam logic [31:0] IVL_RST = 32'(BCN_IVL_US);
   localparam int          AGE_STEP_US = 1000; // one set aged per step
   localparam int          AGE_TICK_DEF = AGE_STEP_US * US_CYC;
   localparam int          NSET    = 256;
   localparam int          SET_W   = 8;
   localparam logic [1:0]  RESP_OK  = 2'h0;
   localparam logic [1:0]  RESP_ERR = 2'h2;

   typedef struct packed {
      logic [2:0]  port;
      logic [47:0] sa;
      logic [47:0] da;
      logic        hsr;
      logic [15:0] seq;
   } rra_frm_s;

   typedef struct packed {
      logic drop;
      logic self_hit;
      logic dup_hit;
   } rra_vrd_s;

   typedef struct packed {
      logic [7:0]  tag;
      logic [15:0] seq;
      logic [2:0]  pt;
   } rra_ent_s;

   typedef enum logic {W_IDLE, W_OPEN} rra_win_e;
endpackage

// ---- dv/rra_lookup_model.sv ----
// lookup engine side model: acknowledges flush requests after a delay
`timescale 1ns/100ps
module rra_lookup_model
   import rra_pkg::*;
#(
   parameter int DLY = 3 // ack comes DLY+1 cycles after the request
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic flush_req,
   output logic      flush_ack
);
   int cnt_ff;
   // a slow ack makes sure the request is really held, not just pulsed
   always_ff @(posedge aclk) begin
      cnt_ff    <= (!aresetn || !flush_req || flush_ack) ? 0 : cnt_ff + 1;
      flush_ack <= aresetn && flush_req && !flush_ack && (cnt_ff >= DLY);
   end
endmodule // rra_lookup_model

// ---- dv/rra_top_bench.sv ----
// self-checking bench of the ring assist: register, beacon, watch and frame tests
`timescale 1ns/100ps
module rra_top_bench
   import rra_pkg::*;
;
   logic                  aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic                  s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic                  s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [AW-1:0]         s_axi_awaddr, s_axi_araddr;
   logic [31:0]           s_axi_wdata, s_axi_rdata;
   logic [3:0]            s_axi_wstrb;
   logic [1:0]            s_axi_bresp, s_axi_rresp;
   logic                  frm_vld, vrd_vld, flush_req, flush_ack, sup_lost;
   rra_frm_s              frm;
   rra_vrd_s              vrd;
   logic [NP-1:0]         acl_to, bcn_tx, fwd_en;
   logic [NFLD-1:0][31:0] bcn_fld;
   int                    num_errors, tests_run, n;

   rra_top #(.AGE_TICK(8)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .frm_vld, .frm, .vrd_vld, .vrd, .acl_to, .bcn_tx, .bcn_fld, .fwd_en,
      .flush_req, .flush_ack, .sup_lost);
   rra_lookup_model model_u (.aclk, .aresetn, .flush_req, .flush_ack);

   // clock at 250 MHz
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one axi write; channels released as each is taken, extra edge keeps drives apart
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      forever begin
         @(posedge aclk);
         s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
         s_axi_wvalid  <= s_axi_wvalid && !s_axi_wready;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            cmp(s_axi_bresp, er);
            break;
         end
      end
      @(posedge aclk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      forever begin
         @(posedge aclk);
         s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
         if (s_axi_rvalid) begin
            s_axi_rready <= 1'b0;
            cmp(s_axi_rdata, exp);
            cmp(s_axi_rresp, er);
            break;
         end
      end
      @(posedge aclk);
   endtask

   // one hsr frame header; verdict looked at in its single cycle
   task automatic fr(input logic [2:0] p, input logic [47:0] sa, input logic [15:0] s,
                     input logic exp);
      frm_vld <= 1'b1;
      frm     <= '{port: p, sa: sa, da: 48'h0000_1111_2222, hsr: 1'b1, seq: s};
      @(posedge aclk);
      frm_vld <= 1'b0;
      @(posedge aclk);
      cmp(vrd_vld, 1'b1);
      cmp(vrd.drop, exp);
      cmp(vrd.self_hit, exp && sa == 48'h1122_3344_5566);
      cmp(vrd.dup_hit, exp && sa != 48'h1122_3344_5566);
   endtask

   task automatic acl(input logic [NP-1:0] m);
      acl_to <= m;
      @(posedge aclk);
      acl_to <= '0;
      @(posedge aclk);
   endtask

   task automatic end_of_test();
      if (num_errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // a hang costs one mismatch and ends the run
   initial begin
      #100000;
      num_errors++;
      end_of_test();
   end

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, frm_vld, acl_to, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      frm = '0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(A_IVL, IVL_RST, RESP_OK);
      rd(A_CTL, 32'h0, RESP_OK);
      rd(12'h7F0, 32'h0, RESP_ERR);
      wr(12'h7F0, 32'h1, RESP_ERR);
      wr(A_FLD0, 32'hA5A5_0001, RESP_OK);
      cmp(bcn_fld[0], 32'hA5A5_0001);
      wr(A_RMAP, 32'h0000_0003, RESP_OK);
      wr(A_IVL, 32'h0000_0002, RESP_OK);
      wr(A_CTL, 32'h0000_0002, RESP_OK);
      while (bcn_tx == '0) @(posedge aclk);
      cmp(bcn_tx, 32'h0000_0003);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (bcn_tx == '0);
      cmp(n, 2 * US_CYC);
      // backup: timeouts 4 us apart exceed a 2 us window, 2 cycles apart do not
      wr(A_CTL, 32'h0000_0004, RESP_OK);
      wr(A_WIN, 32'h0000_0002, RESP_OK);
      acl(7'h01);
      repeat (1000) @(posedge aclk);
      acl(7'h02);
      cmp(sup_lost, 1'b0);
      repeat (1000) @(posedge aclk);
      acl(7'h01);
      acl(7'h02);
      cmp(sup_lost, 1'b1);
      rd(A_STAT, 32'h0000_0103, RESP_OK);
      wr(A_STAT, 32'h0000_0103, RESP_OK);
      cmp(sup_lost, 1'b0);
      rd(A_STAT, 32'h0, RESP_OK);
      wr(A_STP, 32'h0FFF_FFF9, RESP_OK);
      cmp(fwd_en, 32'h0000_007E);
      wr(A_LKC2, 32'h0000_0001, RESP_OK);
      while (!flush_req) @(posedge aclk);
      while (flush_req) @(posedge aclk);
      rd(A_LKC2, 32'h0, RESP_OK);
      wr(A_MACL, 32'h3344_5566, RESP_OK);
      wr(A_MACH, 32'h0000_1122, RESP_OK);
      wr(A_LKC1, 32'h0000_0040, RESP_OK);
      fr(3'd4, 48'h1122_3344_5566, 16'h0001, 1'b1);
      fr(3'd4, 48'h1122_3344_5567, 16'h0001, 1'b0);
      wr(A_LKC1, 32'h0, RESP_OK);
      wr(A_PC2, 32'h0000_0010, RESP_OK);
      fr(3'd4, 48'h1122_3344_5566, 16'h0001, 1'b1);
      fr(3'd3, 48'h1122_3344_5566, 16'h0001, 1'b0);
      wr(A_HMAP, 32'h0000_0003, RESP_OK);
      fr(3'd0, 48'h0A0B_0C0D_0E0F, 16'h0009, 1'b0);
      fr(3'd1, 48'h0A0B_0C0D_0E0F, 16'h0009, 1'b0);
      wr(A_DUPC, 32'h0000_0080, RESP_OK);
      fr(3'd0, 48'h0A0B_0C0D_0E0F, 16'h0007, 1'b0);
      fr(3'd1, 48'h0A0B_0C0D_0E0F, 16'h0007, 1'b1);
      fr(3'd1, 48'h0A0B_0C0D_0E0F, 16'h0007, 1'b0);
      end_of_test();
   end
endmodule // rra_top_bench
